// *** rtl/hs_serdes_control_regs.sv ***
// High-speed serdes PLL and transmit/receive control registers of one channel.
//
// Overview of operation
// - The PLL control register sits at index 0x02, resets to 0x811D and every field reads and writes.
// - Bits 15:10 are reserved storage resetting to 100000 and bits 7 and 5 are reserved storage resetting to zero.
// - The loop bandwidth field resets to 01 for no external jitter cleaner, 10 selects one, 00 and 11 are reserved.
// - The PLL enable resets to one and is forced off while the power-down pin is low or global power-down is set.
// - The PLL multiplier code resets to 1101 for 20x and carries the listed factor codes.
// - The transmit swing code in bits 15:12 resets to 1010 and drives the transmitter.
// - The transmit enable resets to one and is forced off while the power-down pin is low or global power-down is set.
// - The transmit rate code resets to full rate, with half, quarter and eighth rate selectable.
// - The adaptive gain mode resets to 01, holding the attenuator only while locked.
// - The auto-zero calibration mode resets to 00, calibrating when the receiver is enabled.
// - The unscrambled data enable resets to zero and may be set for the reduced rates.
// - The receive enable resets to one and is forced off while the power-down pin is low or global power-down is set.
// - The receive rate code resets to full rate, with half, quarter and eighth rate selectable.
`timescale 1ns/10ps
`default_nettype none
`include "hs_serdes_map.svh"
module hs_serdes_control_regs
(
   input wire logic I_CLK,
   input wire logic I_RESET,
   input wire logic I_MDC,
   input wire logic I_MDIO,
   output logic O_MDIO,
   output logic O_MDIO_OE,
   input wire logic I_CHANNEL_POWERDOWN_N_PIN,
   input wire logic I_GLOBAL_PD,
   output hs_serdes_pkg::loop_bw_type O_PLL_LOOP_BW_SEL,
   output logic O_VCO_LOW_RANGE_SEL,
   output hs_serdes_pkg::pll_mult_type O_PLL_MULTIPLIER_CODE,
   output logic O_PLL_EN,
   output logic [3:0] O_TX_SWING_CODE,
   output logic O_TX_EN,
   output hs_serdes_pkg::rate_type O_TX_RATE_CODE,
   output hs_serdes_pkg::gain_mode_type O_GAIN_LOOP_MODE,
   output hs_serdes_pkg::azcal_type O_AUTOZERO_CAL_MODE,
   output logic O_UNSCRAMBLED_DATA_ENABLE,
   output logic O_RX_EN,
   output hs_serdes_pkg::rate_type O_RX_RATE_CODE
);
   import hs_serdes_pkg::*;

   pll_ctrl_type pll_ff;
   txrx_ctrl_type txrx_ff;
   reg_req_type req;
   logic pd_s1_ff, pd_s2_ff;
   logic pll_en_ff, tx_en_ff, rx_en_ff;
   wire logic wr_pll, wr_txrx, power_ok;
   wire logic [15:0] rd_data;

   mdio_frame_slave u_mdio
   (
      .i_clk(I_CLK),
      .i_reset(I_RESET),
      .i_mdc(I_MDC),
      .i_mdio(I_MDIO),
      .o_mdio(O_MDIO),
      .o_mdio_oe(O_MDIO_OE),
      .o_req(req),
      .i_rd_data(rd_data)
   );

   assign wr_pll = req.wr_en && (req.addr == `HS_PLL_CTRL_ADDR);
   assign wr_txrx = req.wr_en && (req.addr == `HS_TXRX_CTRL_ADDR);

   // Unmapped indices read as zero so a stray read is harmless.
   assign rd_data = (req.addr == `HS_PLL_CTRL_ADDR) ? 16'(pll_ff) :
      (req.addr == `HS_TXRX_CTRL_ADDR) ? 16'(txrx_ff) : 16'h0000;

   // Every bit, reserved ones included, is plain storage.
   always_ff @(posedge I_CLK or posedge I_RESET)
   begin
      if (I_RESET)
         pll_ff <= pll_ctrl_type'(`HS_PLL_CTRL_RST);
      else if (wr_pll)
         pll_ff <= pll_ctrl_type'(req.data);
   end

   always_ff @(posedge I_CLK or posedge I_RESET)
   begin
      if (I_RESET)
         txrx_ff <= txrx_ctrl_type'(`HS_TXRX_CTRL_RST);
      else if (wr_txrx)
         txrx_ff <= txrx_ctrl_type'(req.data);
   end

   // The pin is asynchronous; the global bit comes from a register on I_CLK.
   always_ff @(posedge I_CLK or posedge I_RESET)
   begin
      if (I_RESET)
      begin
         pd_s1_ff <= 1'b0;
         pd_s2_ff <= 1'b0;
      end
      else
      begin
         pd_s1_ff <= I_CHANNEL_POWERDOWN_N_PIN;
         pd_s2_ff <= pd_s1_ff;
      end
   end

   assign power_ok = pd_s2_ff & ~I_GLOBAL_PD;

   // Gating the copies, not the stored bits, lets the written setting return
   // by itself once power-down is released.
   always_ff @(posedge I_CLK or posedge I_RESET)
   begin
      if (I_RESET)
      begin
         pll_en_ff <= 1'b0;
         tx_en_ff <= 1'b0;
         rx_en_ff <= 1'b0;
      end
      else
      begin
         pll_en_ff <= pll_ff.pll_enable_bit & power_ok;
         tx_en_ff <= txrx_ff.tx_enable_bit & power_ok;
         rx_en_ff <= txrx_ff.rx_enable_bit & power_ok;
      end
   end

   assign O_PLL_EN = pll_en_ff;
   assign O_TX_EN = tx_en_ff;
   assign O_RX_EN = rx_en_ff;
   assign O_PLL_LOOP_BW_SEL = pll_ff.pll_loop_bw_sel;
   // The range bit is only stored; choosing it correctly is up to software.
   assign O_VCO_LOW_RANGE_SEL = pll_ff.vco_low_range_sel;
   assign O_PLL_MULTIPLIER_CODE = pll_ff.pll_multiplier_code;
   assign O_TX_SWING_CODE = txrx_ff.tx_swing_code;
   assign O_TX_RATE_CODE = txrx_ff.tx_rate_code;
   assign O_GAIN_LOOP_MODE = txrx_ff.gain_loop_mode;
   assign O_AUTOZERO_CAL_MODE = txrx_ff.autozero_cal_mode;
   assign O_UNSCRAMBLED_DATA_ENABLE = txrx_ff.unscrambled_data_enable;
   assign O_RX_RATE_CODE = txrx_ff.rx_rate_code;

   default clocking cb @(posedge I_CLK);
   endclocking
   default disable iff (I_RESET);

   sequence s_pd_held;
      !I_CHANNEL_POWERDOWN_N_PIN [*3];
   endsequence

   // Four samples cover the pin synchroniser even when the window opens on
   // the edge that releases reset, while the sync stages are still cleared.
   sequence s_power_ok_held;
      (I_CHANNEL_POWERDOWN_N_PIN && !I_GLOBAL_PD) [*4];
   endsequence

   property p_pll_write;
      wr_pll |=> (pll_ff == $past(req.data)) &&
         (O_PLL_MULTIPLIER_CODE == $past(req.data[3:0])) &&
         (O_PLL_LOOP_BW_SEL == $past(req.data[9:8])) &&
         (O_VCO_LOW_RANGE_SEL == $past(req.data[6]));
   endproperty
   a_pll_write: assert property (p_pll_write)
      else $error("PLL control write not stored");

   property p_rsvd_reset;
      $fell(I_RESET) |-> pll_ff.rsvd_hi == `PLL_RSVD_HI_RST &&
         !pll_ff.rsvd7 && !pll_ff.rsvd5;
   endproperty
   a_rsvd_reset: assert property (p_rsvd_reset)
      else $error("Reserved PLL bits wrong after reset");

   property p_loop_bw_reset;
      $fell(I_RESET) |-> O_PLL_LOOP_BW_SEL == `PLL_LOOP_BW_RST;
   endproperty
   a_loop_bw_reset: assert property (p_loop_bw_reset)
      else $error("Loop bandwidth wrong after reset");

   property p_pll_gate;
      (s_pd_held or I_GLOBAL_PD) |=> !O_PLL_EN;
   endproperty
   a_pll_gate: assert property (p_pll_gate)
      else $error("PLL enabled during power-down");

   property p_mult_reset;
      $fell(I_RESET) |-> O_PLL_MULTIPLIER_CODE == `PLL_MULT_RST &&
         O_PLL_EN == 1'b0 && pll_ff.pll_enable_bit;
   endproperty
   a_mult_reset: assert property (p_mult_reset)
      else $error("PLL multiplier wrong after reset");

   property p_swing_follow;
      wr_txrx |=> O_TX_SWING_CODE == $past(req.data[15:12]);
   endproperty
   a_swing_follow: assert property (p_swing_follow)
      else $error("Swing code does not follow write");

   property p_tx_gate;
      (s_pd_held or I_GLOBAL_PD) |=> !O_TX_EN;
   endproperty
   a_tx_gate: assert property (p_tx_gate)
      else $error("Transmitter enabled during power-down");

   property p_txrx_reset;
      $fell(I_RESET) |-> O_TX_RATE_CODE == `RATE_RST &&
         O_GAIN_LOOP_MODE == `GAIN_MODE_RST &&
         O_AUTOZERO_CAL_MODE == `AZCAL_MODE_RST &&
         !O_UNSCRAMBLED_DATA_ENABLE && O_TX_SWING_CODE == `TX_SWING_RST;
   endproperty
   a_txrx_reset: assert property (p_txrx_reset)
      else $error("Transmit/receive control wrong after reset");

   property p_rx_gate;
      (s_pd_held or I_GLOBAL_PD) |=> !O_RX_EN;
   endproperty
   a_rx_gate: assert property (p_rx_gate)
      else $error("Receiver enabled during power-down");

   property p_rx_rate_reset;
      $fell(I_RESET) |-> O_RX_RATE_CODE == `RATE_RST &&
         txrx_ff.rx_enable_bit && txrx_ff.tx_enable_bit;
   endproperty
   a_rx_rate_reset: assert property (p_rx_rate_reset)
      else $error("Receive rate or enables wrong after reset");

   property p_enables_return;
      s_power_ok_held ##0 (!wr_pll && !wr_txrx) |=>
         O_TX_EN == txrx_ff.tx_enable_bit &&
         O_RX_EN == txrx_ff.rx_enable_bit &&
         O_PLL_EN == pll_ff.pll_enable_bit;
   endproperty
   a_enables_return: assert property (p_enables_return)
      else $error("Stored enable not restored after power-down");

   property p_store_kept;
      (!power_ok && !wr_txrx) |=> $stable(txrx_ff);
   endproperty
   a_store_kept: assert property (p_store_kept)
      else $error("Stored enables changed by power-down");

endmodule : hs_serdes_control_regs
`default_nettype wire

// *** rtl/hs_serdes_map.svh ***
// Offsets, field positions, reset values and frame counts of the serdes controls.
`ifndef HS_SERDES_MAP_SVH
`define HS_SERDES_MAP_SVH

// Register indices on the management bus.
`define HS_PLL_CTRL_ADDR 5'h02
`define HS_TXRX_CTRL_ADDR 5'h03

// Reset values of the two registers.
`define HS_PLL_CTRL_RST 16'h811D
`define HS_TXRX_CTRL_RST 16'hA444

// Field resets checked in the control bank.
`define PLL_RSVD_HI_RST 6'h20
`define PLL_LOOP_BW_RST 2'h1
`define PLL_MULT_RST 4'hD
`define TX_SWING_RST 4'hA
`define RATE_RST 2'h0
`define GAIN_MODE_RST 2'h1
`define AZCAL_MODE_RST 2'h0

// Field positions of the power enables.
`define PLL_ENABLE_POS 4
`define TX_ENABLE_POS 10
`define RX_ENABLE_POS 2

// Management frame constants; the port address value is arbitrary.
`define MDIO_PORT_ADDR 5'h00
`define MDIO_PRE_LEN 6'h20
`define MDIO_OP_READ 2'h2
`define MDIO_OP_WRITE 2'h1

`endif

// *** rtl/hs_serdes_pkg.sv ***
// Types shared by the serdes control bank and its management frame slave.
package hs_serdes_pkg;

   typedef enum logic [1:0] {LBW_RSVD0 = 2'h0, LBW_INTERNAL = 2'h1,
      LBW_EXT_JITTER_CLEAN = 2'h2, LBW_RSVD3 = 2'h3} loop_bw_type;

   typedef enum logic [3:0] {MULT_RSVD0 = 4'h0, MULT_RSVD1 = 4'h1,
      MULT_4X = 4'h2, MULT_5X = 4'h3, MULT_6X = 4'h4, MULT_8X = 4'h5,
      MULT_8P25X = 4'h6, MULT_10X = 4'h7, MULT_12X = 4'h8,
      MULT_12P5X = 4'h9, MULT_15X = 4'hA, MULT_16X = 4'hB,
      MULT_16P5X = 4'hC, MULT_20X = 4'hD, MULT_25X = 4'hE,
      MULT_RSVD15 = 4'hF} pll_mult_type;

   typedef enum logic [1:0] {RATE_FULL = 2'h0, RATE_HALF = 2'h1,
      RATE_QUARTER = 2'h2, RATE_EIGHTH = 2'h3} rate_type;

   typedef enum logic [1:0] {GAIN_FREEZE_FIRST_LOCK = 2'h0,
      GAIN_HOLD_IN_LOCK = 2'h1, GAIN_ATTEN_OFF = 2'h2,
      GAIN_ATTEN_ON = 2'h3} gain_mode_type;

   typedef enum logic [1:0] {AZCAL_ON_RX_ENABLE = 2'h0, AZCAL_OFF = 2'h1,
      AZCAL_FORCE_UPDATE = 2'h2, AZCAL_FORCE_NO_UPDATE = 2'h3} azcal_type;

   typedef struct packed {
      logic [5:0] rsvd_hi;
      loop_bw_type pll_loop_bw_sel;
      logic rsvd7;
      logic vco_low_range_sel;
      logic rsvd5;
      logic pll_enable_bit;
      pll_mult_type pll_multiplier_code;
   } pll_ctrl_type;

   typedef struct packed {
      logic [3:0] tx_swing_code;
      logic rsvd11;
      logic tx_enable_bit;
      rate_type tx_rate_code;
      gain_mode_type gain_loop_mode;
      azcal_type autozero_cal_mode;
      logic unscrambled_data_enable;
      logic rx_enable_bit;
      rate_type rx_rate_code;
   } txrx_ctrl_type;

   typedef struct packed {
      logic wr_en;
      logic [4:0] addr;
      logic [15:0] data;
   } reg_req_type;

   // Gray codes along the frame order.
   typedef enum logic [2:0] {MDIO_PRE = 3'h0, MDIO_START = 3'h1,
      MDIO_OPC = 3'h3, MDIO_ADDR = 3'h2, MDIO_TURN = 3'h6,
      MDIO_DATA = 3'h7} mdio_state_type;

endpackage : hs_serdes_pkg

// *** rtl/mdio_frame_slave.sv ***
// Management serial frame slave: decodes read and write frames for the bank.
`timescale 1ns/10ps
`default_nettype none
`include "hs_serdes_map.svh"
module mdio_frame_slave
(
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic i_mdc,
   input wire logic i_mdio,
   output logic o_mdio,
   output logic o_mdio_oe,
   output hs_serdes_pkg::reg_req_type o_req,
   input wire logic [15:0] i_rd_data
);
   import hs_serdes_pkg::*;

   logic mdc_s1_ff, mdc_s2_ff, mdc_d_ff, dio_s1_ff, dio_s2_ff;
   mdio_state_type state_ff, nxt_state;
   logic [5:0] cnt_ff, nxt_cnt;
   logic [15:0] shift_ff, nxt_shift;
   logic [4:0] addr_ff, nxt_addr;
   logic rd_ff, nxt_rd, hit_ff, nxt_hit;
   logic out_ff, nxt_out, oe_ff, nxt_oe, wr_ff, nxt_wr;
   wire logic rise;
   wire logic [15:0] shift_in;
   wire logic [1:0] opcode;

   // Both pins come from the host's domain; the first stage feeds only the second.
   always_ff @(posedge i_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         // The clock pin idles high, so the edge stages start high as well;
         // otherwise a false rise would follow every release of reset.
         mdc_s1_ff <= 1'b1;
         mdc_s2_ff <= 1'b1;
         mdc_d_ff <= 1'b1;
         dio_s1_ff <= 1'b1;
         dio_s2_ff <= 1'b1;
      end
      else
      begin
         mdc_s1_ff <= i_mdc;
         mdc_s2_ff <= mdc_s1_ff;
         mdc_d_ff <= mdc_s2_ff;
         dio_s1_ff <= i_mdio;
         dio_s2_ff <= dio_s1_ff;
      end
   end

   assign rise = mdc_s2_ff & ~mdc_d_ff;
   assign shift_in = {shift_ff[14:0], dio_s2_ff};
   assign opcode = shift_in[11:10];

   always_comb
   begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      nxt_shift = shift_ff;
      nxt_addr = addr_ff;
      nxt_rd = rd_ff;
      nxt_hit = hit_ff;
      nxt_out = out_ff;
      nxt_oe = oe_ff;
      nxt_wr = 1'b0;
      if (rise)
      begin
         nxt_cnt = cnt_ff + 6'h01;
         unique case (state_ff)
            MDIO_PRE:
            begin
               nxt_oe = 1'b0;
               if (dio_s2_ff)
                  nxt_cnt = (cnt_ff == `MDIO_PRE_LEN) ? cnt_ff : cnt_ff + 6'h01;
               else
               begin
                  nxt_cnt = 6'h00;
                  if (cnt_ff == `MDIO_PRE_LEN)
                     nxt_state = MDIO_START;
               end
            end
            MDIO_START:
            begin
               nxt_cnt = 6'h00;
               nxt_state = dio_s2_ff ? MDIO_OPC : MDIO_PRE;
            end
            MDIO_OPC:
            begin
               nxt_shift = shift_in;
               if (cnt_ff == 6'h01)
               begin
                  nxt_cnt = 6'h00;
                  nxt_state = MDIO_ADDR;
               end
            end
            MDIO_ADDR:
            begin
               nxt_shift = shift_in;
               if (cnt_ff == 6'h09)
               begin
                  nxt_cnt = 6'h00;
                  nxt_state = MDIO_TURN;
                  nxt_rd = (opcode == `MDIO_OP_READ);
                  nxt_hit = (shift_in[9:5] == `MDIO_PORT_ADDR) &&
                     (opcode == `MDIO_OP_READ || opcode == `MDIO_OP_WRITE);
                  nxt_addr = shift_in[4:0];
               end
            end
            MDIO_TURN:
            begin
               // The first turnaround bit stays released so the host can let go.
               if (cnt_ff == 6'h01)
               begin
                  nxt_cnt = 6'h00;
                  nxt_state = MDIO_DATA;
                  nxt_oe = rd_ff & hit_ff;
                  nxt_out = 1'b0;
                  nxt_shift = i_rd_data;
               end
            end
            MDIO_DATA:
            begin
               if (rd_ff)
               begin
                  nxt_out = shift_ff[15];
                  nxt_shift = {shift_ff[14:0], 1'b0};
               end
               else
                  nxt_shift = shift_in;
               if (cnt_ff == 6'h0F)
               begin
                  nxt_cnt = 6'h00;
                  nxt_state = MDIO_PRE;
                  nxt_wr = hit_ff & ~rd_ff;
               end
            end
            default:
               nxt_state = MDIO_PRE;
         endcase
      end
   end

   always_ff @(posedge i_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         state_ff <= MDIO_PRE;
         cnt_ff <= 6'h00;
         shift_ff <= 16'h0000;
         addr_ff <= 5'h00;
         rd_ff <= 1'b0;
         hit_ff <= 1'b0;
         out_ff <= 1'b1;
         oe_ff <= 1'b0;
         wr_ff <= 1'b0;
      end
      else
      begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         shift_ff <= nxt_shift;
         addr_ff <= nxt_addr;
         rd_ff <= nxt_rd;
         hit_ff <= nxt_hit;
         out_ff <= nxt_out;
         oe_ff <= nxt_oe;
         wr_ff <= nxt_wr;
      end
   end

   assign o_mdio = out_ff;
   assign o_mdio_oe = oe_ff;
   assign o_req = '{wr_en: wr_ff, addr: addr_ff, data: shift_ff};

endmodule : mdio_frame_slave
`default_nettype wire

// *** tb/hs_serdes_control_regs_tb.sv ***
// Self-checking testbench of the serdes control register bank.
`timescale 1ns/10ps
`default_nettype none
`include "hs_serdes_map.svh"
module hs_serdes_control_regs_tb;
   import hs_serdes_pkg::*;
   logic clk, rst, pd_n, gpd, mdc, mdio_line, dev_mdio, dev_oe;
   logic vco, pll_en, tx_en, rx_en, unsd;
   logic [3:0] swing;
   loop_bw_type bw;
   pll_mult_type mult;
   rate_type tx_rate;
   rate_type rx_rate;
   gain_mode_type gain;
   azcal_type azcal;
   logic [15:0] pll_obs;
   logic [15:0] txrx_obs;
   logic [15:0] en_obs;
   int error_cnt;
   int checks;
   assign pll_obs = {6'h00, bw, 1'b0, vco, 1'b0, pll_en, mult};
   assign txrx_obs = {swing, 1'b0, tx_en, tx_rate, gain, azcal, unsd, rx_en,
      rx_rate};
   assign en_obs = {13'h0000, pll_en, tx_en, rx_en};
   initial
   begin
      clk = 1'b0;
      rst = 1'b1;
      pd_n = 1'b1;
      gpd = 1'b0;
   end
   always #2 clk = ~clk;
   hs_serdes_control_regs uut
   (
      .I_CLK(clk), .I_RESET(rst), .I_MDC(mdc), .I_MDIO(mdio_line),
      .O_MDIO(dev_mdio), .O_MDIO_OE(dev_oe),
      .I_CHANNEL_POWERDOWN_N_PIN(pd_n), .I_GLOBAL_PD(gpd),
      .O_PLL_LOOP_BW_SEL(bw), .O_VCO_LOW_RANGE_SEL(vco),
      .O_PLL_MULTIPLIER_CODE(mult), .O_PLL_EN(pll_en),
      .O_TX_SWING_CODE(swing), .O_TX_EN(tx_en), .O_TX_RATE_CODE(tx_rate),
      .O_GAIN_LOOP_MODE(gain), .O_AUTOZERO_CAL_MODE(azcal),
      .O_UNSCRAMBLED_DATA_ENABLE(unsd), .O_RX_EN(rx_en),
      .O_RX_RATE_CODE(rx_rate)
   );
   mdio_host_model mgmt
   (
      .i_clk(clk), .i_dev_mdio(dev_mdio), .i_dev_oe(dev_oe), .o_mdc(mdc),
      .o_mdio_line(mdio_line)
   );
   task automatic report_and_stop;
      if (error_cnt == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : report_and_stop
   task automatic chk(input logic [15:0] got, input logic [15:0] exp,
      input string msg);
      checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("wrong value at %0t: %s got %h expected %h", $time, msg,
            got, exp);
      end
   endtask : chk
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      logic [15:0] x;
      mgmt.xfer(`MDIO_OP_WRITE, `MDIO_PORT_ADDR, a, d, x);
      repeat (3) @(posedge clk);
   endtask : wr
   task automatic rd(input logic [4:0] a, output logic [15:0] d);
      mgmt.xfer(`MDIO_OP_READ, `MDIO_PORT_ADDR, a, 16'h0000, d);
   endtask : rd
   // Fields are compared with reserved bits masked, which assumes power-up.
   task automatic expect_reg(input logic [4:0] a, input logic [15:0] e);
      logic [15:0] v;
      rd(a, v);
      chk(v, e, "readback");
      if (a == `HS_PLL_CTRL_ADDR)
         chk(pll_obs, e & 16'h035F, "pll fields");
      else
         chk(txrx_obs, e & 16'hF7FF, "txrx fields");
   endtask : expect_reg
   task automatic t_reset;
      chk(en_obs, 16'h0007, "enables after reset");
      expect_reg(`HS_PLL_CTRL_ADDR, 16'h811D);
      expect_reg(`HS_TXRX_CTRL_ADDR, 16'hA444);
   endtask : t_reset
   task automatic t_pll_codes;
      logic [3:0] c;
      logic lo;
      logic [15:0] d;
      for (int i = 0; i < 16; i++)
      begin
         c = 4'(i);
         // A 250 MHz reference stays below 2.5 GHz up to the 8.25x code.
         lo = (c < 4'h7);
         d = {c, c[1:0], c[1:0], c[0], lo, c[1], ~c[3], c};
         wr(`HS_PLL_CTRL_ADDR, d);
         expect_reg(`HS_PLL_CTRL_ADDR, d);
      end
   endtask : t_pll_codes
   task automatic t_txrx_codes;
      logic [1:0] c;
      logic [15:0] d;
      for (int i = 0; i < 4; i++)
      begin
         c = 2'(i);
         d = {c, ~c, c[0], c[1], c, c, ~c, c[0], ~c[1], ~c};
         wr(`HS_TXRX_CTRL_ADDR, d);
         expect_reg(`HS_TXRX_CTRL_ADDR, d);
      end
   endtask : t_txrx_codes
   task automatic t_powerdown;
      logic [15:0] v;
      wr(`HS_PLL_CTRL_ADDR, 16'h811D);
      wr(`HS_TXRX_CTRL_ADDR, 16'hA444);
      pd_n <= 1'b0;
      repeat (5) @(posedge clk);
      chk(en_obs, 16'h0000, "pin power-down");
      rd(`HS_PLL_CTRL_ADDR, v);
      chk(v, 16'h811D, "stored pll enable");
      rd(`HS_TXRX_CTRL_ADDR, v);
      chk(v, 16'hA444, "stored txrx enables");
      pd_n <= 1'b1;
      repeat (5) @(posedge clk);
      chk(en_obs, 16'h0007, "pin released");
      gpd <= 1'b1;
      repeat (2) @(posedge clk);
      #1;
      chk(en_obs, 16'h0000, "global power-down");
      @(posedge clk);
      gpd <= 1'b0;
      repeat (3) @(posedge clk);
      chk(en_obs, 16'h0007, "global released");
      wr(`HS_TXRX_CTRL_ADDR, 16'hA040);
      chk(en_obs, 16'h0004, "stored enables off");
   endtask : t_powerdown
   task automatic t_refuse;
      logic [15:0] v;
      mgmt.xfer(`MDIO_OP_WRITE, 5'h01, `HS_PLL_CTRL_ADDR, 16'h0000, v);
      mgmt.xfer(2'h0, `MDIO_PORT_ADDR, `HS_PLL_CTRL_ADDR, 16'h0000, v);
      mgmt.xfer(2'h3, `MDIO_PORT_ADDR, `HS_PLL_CTRL_ADDR, 16'h0000, v);
      expect_reg(`HS_PLL_CTRL_ADDR, 16'h811D);
      mgmt.xfer(`MDIO_OP_READ, 5'h01, `HS_PLL_CTRL_ADDR, 16'h0000, v);
      chk(v, 16'hFFFF, "foreign port left line idle");
      wr(5'h1F, 16'hFFFF);
      rd(5'h1F, v);
      chk(v, 16'h0000, "unmapped register");
   endtask : t_refuse
   task automatic t_midreset;
      wr(`HS_TXRX_CTRL_ADDR, 16'h0000);
      wr(`HS_PLL_CTRL_ADDR, 16'h0000);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      repeat (5) @(posedge clk);
      t_reset;
   endtask : t_midreset
   initial
   begin
      error_cnt = 0;
      checks = 0;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      repeat (5) @(posedge clk);
      t_reset;
      t_pll_codes;
      t_txrx_codes;
      t_powerdown;
      t_refuse;
      t_midreset;
      report_and_stop;
   end
   // About 60 frames of some 650 clocks each fit well inside this span.
   initial
   begin
      repeat (70000) @(posedge clk);
      error_cnt++;
      report_and_stop;
   end
endmodule : hs_serdes_control_regs_tb
`default_nettype wire

// *** tb/mdio_host_model.sv ***
// Management host model that clocks clause 22 frames onto the serial pins.
`timescale 1ns/10ps
`default_nettype none
module mdio_host_model
(
   input wire logic i_clk,
   input wire logic i_dev_mdio,
   input wire logic i_dev_oe,
   output logic o_mdc,
   output logic o_mdio_line
);
   logic drive_en;
   logic drive_val;
   // The line has a pull-up, so with both ends released it reads one.
   assign o_mdio_line = i_dev_oe ? i_dev_mdio : (drive_en ? drive_val : 1'b1);
   initial
   begin
      o_mdc = 1'b1;
      drive_en = 1'b0;
      drive_val = 1'b1;
   end
   // Data changes with the falling edge and is sampled just before the rise,
   // so each half period of five clocks leaves margin for the input sync.
   task automatic clock_bit(input logic en, input logic val, output logic smp);
      @(posedge i_clk);
      o_mdc <= 1'b0;
      drive_en <= en;
      drive_val <= val;
      repeat (5) @(posedge i_clk);
      smp = o_mdio_line;
      o_mdc <= 1'b1;
      repeat (4) @(posedge i_clk);
   endtask : clock_bit
   task automatic xfer(input logic [1:0] op, input logic [4:0] phy,
      input logic [4:0] reg_a, input logic [15:0] wdata,
      output logic [15:0] rdata);
      logic [13:0] head;
      logic s;
      head = {2'b01, op, phy, reg_a};
      rdata = 16'h0000;
      repeat (32) clock_bit(1'b1, 1'b1, s);
      for (int i = 13; i >= 0; i--) clock_bit(1'b1, head[i], s);
      if (op == 2'h2)
      begin
         // Turnaround and data with the line released; the first data rise
         // only launches bit 15, and the last rise ends the device drive.
         repeat (3) clock_bit(1'b0, 1'b1, s);
         for (int i = 15; i >= 0; i--)
         begin
            clock_bit(1'b0, 1'b1, s);
            rdata[i] = s;
         end
      end
      else
      begin
         clock_bit(1'b1, 1'b1, s);
         clock_bit(1'b1, 1'b0, s);
         for (int i = 15; i >= 0; i--) clock_bit(1'b1, wdata[i], s);
      end
      @(posedge i_clk);
      drive_en <= 1'b0;
   endtask : xfer
endmodule : mdio_host_model
`default_nettype wire
